// ---- shared/clksw_pkg.sv ----
// Constants, field positions and state types for the clock switch and fail monitor
package clksw_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int CNT_W = 11;
	localparam int FAIL_W = 16;
	localparam int OSC_N = 5;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_OSC_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_OSC_SET = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_OSC_CLR = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_OSC_INV = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_CLK_STAT = 12'h0d0;
	localparam logic [ADDR_W-1:0] OFS_SYS_KEY = 12'h100;

	localparam logic [DATA_W-1:0] KEY_FIRST = 32'haa996655;
	localparam logic [DATA_W-1:0] KEY_SECOND = 32'h556699aa;

	// Control register field positions
	localparam int POS_FRCDIV = 24;
	localparam int POS_COSC = 12;
	localparam int POS_NOSC = 8;
	localparam int POS_CLKLOCK = 7;
	localparam int POS_SLPEN = 4;
	localparam int POS_CF = 3;
	localparam int POS_SOSCEN = 1;
	localparam int POS_SWITCH_REQUEST_BIT = 0;

	// Status register field positions
	localparam int POS_PLLRDY = 7;
	localparam int POS_LPRCRDY = 5;
	localparam int POS_SOSCRDY = 4;
	localparam int POS_POSCRDY = 2;
	localparam int POS_FRCRDY = 0;

	// Source select codes
	localparam logic [2:0] SRC_FRC = 3'h0;
	localparam logic [2:0] SRC_PLL = 3'h1;
	localparam logic [2:0] SRC_PRI = 3'h2;
	localparam logic [2:0] SRC_SEC = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;

	// Oscillator enable and tick bit indices
	localparam logic [2:0] OSC_FRC = 3'h0;
	localparam logic [2:0] OSC_PRI = 3'h1;
	localparam logic [2:0] OSC_SEC = 3'h2;
	localparam logic [2:0] OSC_LOW_POWER_RC_OSC = 3'h3;
	localparam logic [2:0] OSC_PLL = 3'h4;

	// Primary submode configuration codes
	localparam logic [1:0] SUB_EC = 2'h0;
	localparam logic [1:0] SUB_XT = 2'h1;
	localparam logic [1:0] SUB_HS = 2'h2;

	localparam logic [2:0] RST_FRCDIV = 3'h0;
	localparam logic [2:0] FRCDIV_MAX = 3'h7;
	localparam logic [3:0] FRC_SHIFT_MAX = 4'h8;

	localparam logic [CNT_W-1:0] OST_TICKS = 11'd1024;
	localparam logic [CNT_W-1:0] SWITCH_TICKS = 11'd10;

	localparam int MCLK_PERIOD_NS = 5;
	localparam int FAIL_TIME_NS = 100000;
	localparam int FAIL_CYCLES_DEF = FAIL_TIME_NS / MCLK_PERIOD_NS;

	typedef enum logic [2:0] {SW_IDLE, SW_CHECK, SW_START, SW_PLL, SW_COUNT} sw_e;
	typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} key_e;
endpackage

// ---- shared/fail_mon_if.sv ----
// Signals between the switch controller and the clock fail monitor
`timescale 1ns/10ps
interface fail_mon_if;
	logic enable;
	logic tick;
	logic fail;

	modport ctrl (output enable, output tick, input fail);
	modport monitor (input enable, input tick, output fail);
endinterface

// ---- logic/clock_fail_monitor.sv ----
// Watchdog on system clock ticks that flags a lost clock
`timescale 1ns/10ps
module clock_fail_monitor
	import clksw_pkg::*;
#(
	parameter logic [FAIL_W-1:0] FAIL_CYCLES = FAIL_W'(FAIL_CYCLES_DEF)
)
(
	input wire logic mclk,
	input wire logic rst,
	fail_mon_if.monitor mon
);
	typedef struct packed
	{
		logic [FAIL_W-1:0] cnt;
		logic fail;
	} mon_s;

	mon_s mon_r;
	mon_s mon_nxt;

	always_comb
	begin
		mon_nxt = mon_r;
		mon_nxt.fail = 1'b0;
		// Held cleared while disabled, so sleep or a locked config never trips it
		if (!mon.enable || mon.tick)
		begin
			mon_nxt.cnt = '0;
		end
		else if (mon_r.cnt == FAIL_CYCLES - 1'b1)
		begin
			mon_nxt.cnt = '0;
			mon_nxt.fail = 1'b1;
		end
		else
		begin
			mon_nxt.cnt = mon_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mon_r <= '0;
		end
		else
		begin
			mon_r <= mon_nxt;
		end
	end

	assign mon.fail = mon_r.fail;
endmodule

// ---- logic/clock_switch_and_fail_monitor.sv ----
// Clock source switch controller with key-protected control register
`timescale 1ns/10ps

module clock_switch_and_fail_monitor
	import clksw_pkg::*;
#(
	parameter logic [FAIL_W-1:0] FAIL_CYCLES = FAIL_W'(FAIL_CYCLES_DEF)
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rd_data,
	input wire logic switch_enable_config_bit,
	input wire logic [2:0] initial_source_config,
	input wire logic [1:0] primary_submode_config,
	input wire logic pll_from_primary,
	input wire logic pll_lock,
	input wire logic sleep_mode,
	input wire logic [OSC_N-1:0] osc_tick,
	input wire logic [OSC_N-1:0] periph_osc_request,
	output logic [OSC_N-1:0] osc_enable,
	output logic [2:0] system_clock_sel,
	output logic system_clock_run,
	output logic [3:0] fast_rc_div_shift,
	output logic switch_busy,
	output logic nmi
);
	typedef struct packed
	{
		sw_e state;
		key_e key;
		logic loaded;
		logic [2:0] cosc;
		logic [2:0] nosc;
		logic [2:0] target;
		logic [2:0] frcdiv;
		logic clklock;
		logic slpen;
		logic cf;
		logic soscen;
		logic switch_request_bit;
		logic pll_rdy;
		logic skip_ost;
		logic [CNT_W-1:0] cnt;
		logic [OSC_N-1:0] osc_en;
		logic [3:0] div_shift;
		logic sys_run;
		logic nmi;
		logic [DATA_W-1:0] rd_data;
	} ctl_s;

	ctl_s ctl_r;
	ctl_s ctl_nxt;

	fail_mon_if mon ();

	// Oscillators a source code needs running
	function automatic logic [OSC_N-1:0] osc_need(input logic [2:0] code, input logic pll_pri);
		logic [OSC_N-1:0] m;
		m = '0;
		unique case (code)
			SRC_PLL:
			begin
				m[OSC_PLL] = 1'b1;
				m[pll_pri ? OSC_PRI : OSC_FRC] = 1'b1;
			end
			SRC_PRI: m[OSC_PRI] = 1'b1;
			SRC_SEC: m[OSC_SEC] = 1'b1;
			SRC_LOW_POWER_RC_OSC: m[OSC_LOW_POWER_RC_OSC] = 1'b1;
			default: m[OSC_FRC] = 1'b1;
		endcase
		return m;
	endfunction

	// Oscillator whose ticks clock a source code
	function automatic logic [2:0] osc_index(input logic [2:0] code);
		logic [2:0] i;
		i = OSC_FRC;
		unique case (code)
			SRC_PLL: i = OSC_PLL;
			SRC_PRI: i = OSC_PRI;
			SRC_SEC: i = OSC_SEC;
			SRC_LOW_POWER_RC_OSC: i = OSC_LOW_POWER_RC_OSC;
			default: i = OSC_FRC;
		endcase
		return i;
	endfunction

	// Oscillator that must start first for a source code
	function automatic logic [2:0] base_index(input logic [2:0] code, input logic pll_pri);
		logic [2:0] i;
		i = osc_index(code);
		if (code == SRC_PLL)
		begin
			i = pll_pri ? OSC_PRI : OSC_FRC;
		end
		return i;
	endfunction

	logic [DATA_W-1:0] ctrl_word;
	logic [DATA_W-1:0] stat_word;
	logic [DATA_W-1:0] wval;
	logic ctrl_hit;
	logic [2:0] base;
	logic crystal;

	always_comb
	begin
		ctrl_word = '0;
		ctrl_word[POS_FRCDIV +: 3] = ctl_r.frcdiv;
		ctrl_word[POS_COSC +: 3] = ctl_r.cosc;
		ctrl_word[POS_NOSC +: 3] = ctl_r.nosc;
		ctrl_word[POS_CLKLOCK] = ctl_r.clklock;
		ctrl_word[POS_SLPEN] = ctl_r.slpen;
		ctrl_word[POS_CF] = ctl_r.cf;
		ctrl_word[POS_SOSCEN] = ctl_r.soscen;
		ctrl_word[POS_SWITCH_REQUEST_BIT] = ctl_r.switch_request_bit;
		stat_word = '0;
		stat_word[POS_PLLRDY] = ctl_r.pll_rdy;
		stat_word[POS_LPRCRDY] = ctl_r.osc_en[OSC_LOW_POWER_RC_OSC];
		stat_word[POS_SOSCRDY] = ctl_r.osc_en[OSC_SEC];
		stat_word[POS_POSCRDY] = ctl_r.osc_en[OSC_PRI];
		stat_word[POS_FRCRDY] = ctl_r.osc_en[OSC_FRC];
	end

	always_comb
	begin
		ctl_nxt = ctl_r;
		ctl_nxt.nmi = 1'b0;
		ctl_nxt.rd_data = '0;
		base = base_index(ctl_r.target, pll_from_primary);
		// EC needs no startup timer; the secondary is always a crystal
		crystal = (base == OSC_SEC) ||
			((base == OSC_PRI) && (primary_submode_config != SUB_EC));

		// Key sequence: the first word always restarts it; any other unexpected write relocks
		if (wr_en && (addr == OFS_SYS_KEY))
		begin
			if (wr_data == KEY_FIRST)
			begin
				ctl_nxt.key = KEY_HALF;
			end
			else if ((ctl_r.key == KEY_HALF) && (wr_data == KEY_SECOND))
			begin
				ctl_nxt.key = KEY_OPEN;
			end
			else
			begin
				ctl_nxt.key = KEY_LOCKED;
			end
		end

		// Plain, set, clear and invert views of the control register
		ctrl_hit = wr_en && (ctl_r.key == KEY_OPEN) && (addr == OFS_OSC_CTRL ||
			addr == OFS_OSC_SET || addr == OFS_OSC_CLR || addr == OFS_OSC_INV);
		if (addr == OFS_OSC_SET)
		begin
			wval = ctrl_word | wr_data;
		end
		else if (addr == OFS_OSC_CLR)
		begin
			wval = ctrl_word & ~wr_data;
		end
		else if (addr == OFS_OSC_INV)
		begin
			wval = ctrl_word ^ wr_data;
		end
		else
		begin
			wval = wr_data;
		end
		if (ctrl_hit)
		begin
			ctl_nxt.frcdiv = wval[POS_FRCDIV +: 3];
			ctl_nxt.nosc = wval[POS_NOSC +: 3];
			ctl_nxt.clklock = wval[POS_CLKLOCK];
			ctl_nxt.slpen = wval[POS_SLPEN];
			ctl_nxt.cf = wval[POS_CF];
			ctl_nxt.soscen = wval[POS_SOSCEN];
			// A request is only taken while no switch runs; hardware does the clearing
			if (wval[POS_SWITCH_REQUEST_BIT] && (ctl_r.state == SW_IDLE))
			begin
				ctl_nxt.switch_request_bit = 1'b1;
			end
		end

		unique case (ctl_r.state)
			SW_IDLE:
			begin
				if (ctl_r.switch_request_bit)
				begin
					ctl_nxt.state = SW_CHECK;
				end
			end
			SW_CHECK:
			begin
				if (ctl_r.nosc == ctl_r.cosc)
				begin
					ctl_nxt.switch_request_bit = 1'b0;
					ctl_nxt.state = SW_IDLE;
				end
				else
				begin
					ctl_nxt.pll_rdy = 1'b0;
					ctl_nxt.cf = 1'b0;
					ctl_nxt.target = ctl_r.nosc;
					ctl_nxt.skip_ost = ctl_r.osc_en[base_index(ctl_r.nosc, pll_from_primary)];
					ctl_nxt.cnt = '0;
					ctl_nxt.state = SW_START;
				end
			end
			SW_START:
			begin
				if (ctl_r.skip_ost || !crystal)
				begin
					ctl_nxt.state = SW_PLL;
				end
				else if (osc_tick[base])
				begin
					if (ctl_r.cnt == OST_TICKS - 1'b1)
					begin
						ctl_nxt.cnt = '0;
						ctl_nxt.state = SW_PLL;
					end
					else
					begin
						ctl_nxt.cnt = ctl_r.cnt + 1'b1;
					end
				end
			end
			SW_PLL:
			begin
				if ((ctl_r.target != SRC_PLL) || ctl_r.pll_rdy)
				begin
					ctl_nxt.cnt = '0;
					ctl_nxt.state = SW_COUNT;
				end
			end
			SW_COUNT:
			begin
				if (osc_tick[osc_index(ctl_r.target)])
				begin
					if (ctl_r.cnt == SWITCH_TICKS - 1'b1)
					begin
						ctl_nxt.cosc = ctl_r.target;
						ctl_nxt.switch_request_bit = 1'b0;
						ctl_nxt.state = SW_IDLE;
					end
					else
					begin
						ctl_nxt.cnt = ctl_r.cnt + 1'b1;
					end
				end
			end
		endcase

		// Lock indication sets after the switch-start clear, so it wins
		if (pll_lock && ctl_r.osc_en[OSC_PLL])
		begin
			ctl_nxt.pll_rdy = 1'b1;
		end

		// Loss of clock aborts any switch and falls back to fast RC
		if (mon.fail)
		begin
			ctl_nxt.cosc = SRC_FRC;
			ctl_nxt.cf = 1'b1;
			ctl_nxt.nmi = 1'b1;
			ctl_nxt.switch_request_bit = 1'b0;
			ctl_nxt.state = SW_IDLE;
		end

		if (!ctl_r.loaded)
		begin
			ctl_nxt.cosc = initial_source_config;
			ctl_nxt.nosc = initial_source_config;
			ctl_nxt.loaded = 1'b1;
		end

		if (switch_enable_config_bit)
		begin
			ctl_nxt.cosc = initial_source_config;
			ctl_nxt.switch_request_bit = 1'b0;
			ctl_nxt.state = SW_IDLE;
		end

		// Old source drops out once current-source moves on, unless periph_osc_request or soscen keeps it enabled
		ctl_nxt.osc_en = osc_need(ctl_nxt.cosc, pll_from_primary) | periph_osc_request;
		if ((ctl_nxt.state != SW_IDLE) && (ctl_nxt.state != SW_CHECK))
		begin
			ctl_nxt.osc_en = ctl_nxt.osc_en | osc_need(ctl_nxt.target, pll_from_primary);
		end
		if (ctl_nxt.soscen)
		begin
			ctl_nxt.osc_en[OSC_SEC] = 1'b1;
		end

		ctl_nxt.div_shift = (ctl_nxt.frcdiv == FRCDIV_MAX) ? FRC_SHIFT_MAX :
			{1'b0, ctl_nxt.frcdiv};
		ctl_nxt.sys_run = !sleep_mode;

		// Reads answer next cycle with no wait even mid-switch
		if (rd_en)
		begin
			if (addr == OFS_OSC_CTRL)
			begin
				ctl_nxt.rd_data = ctrl_word;
			end
			else if (addr == OFS_CLK_STAT)
			begin
				ctl_nxt.rd_data = stat_word;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ctl_r <= '0;
			ctl_r.state <= SW_IDLE;
			ctl_r.key <= KEY_LOCKED;
			ctl_r.cosc <= SRC_FRC;
			ctl_r.nosc <= SRC_FRC;
			ctl_r.target <= SRC_FRC;
			ctl_r.frcdiv <= RST_FRCDIV;
			ctl_r.osc_en[OSC_FRC] <= 1'b1;
		end
		else
		begin
			ctl_r <= ctl_nxt;
		end
	end

	// Monitor runs only when enabled by config and the device is awake
	assign mon.enable = !switch_enable_config_bit && !sleep_mode && ctl_r.loaded;
	assign mon.tick = osc_tick[osc_index(ctl_r.cosc)];

	clock_fail_monitor #(
		.FAIL_CYCLES(FAIL_CYCLES)
	) u_mon (
		.mclk(mclk),
		.rst(rst),
		.mon(mon.monitor)
	);

	assign rd_data = ctl_r.rd_data;
	assign osc_enable = ctl_r.osc_en;
	assign system_clock_sel = ctl_r.cosc;
	assign system_clock_run = ctl_r.sys_run;
	assign fast_rc_div_shift = ctl_r.div_shift;
	assign switch_busy = ctl_r.switch_request_bit;
	assign nmi = ctl_r.nmi;
endmodule

// ---- dv/clksw_monitor.sv ----
// Port checker for the clock switch controller
`timescale 1ns/10ps
module clksw_monitor
	import clksw_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic rd_en,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic sleep_mode,
	input wire logic switch_enable_config_bit,
	input wire logic switch_busy,
	input wire logic nmi,
	input wire logic [2:0] system_clock_sel,
	input wire logic system_clock_run
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 32'h0)
		else $error("read data not idle");
	nmi_pulse_a: assert property (nmi |=> !nmi)
		else $error("nmi longer than one cycle");
	nmi_frc_a: assert property (nmi |-> ##[0:1] system_clock_sel == SRC_FRC)
		else $error("no fallback to fast rc");
	off_busy_a: assert property (switch_enable_config_bit |-> !switch_busy)
		else $error("request set while switching off");
	off_nmi_a: assert property (switch_enable_config_bit |-> !nmi)
		else $error("nmi while monitor off");
	sleep_gate_a: assert property ($rose(sleep_mode) |=> !system_clock_run)
		else $error("clock not gated in sleep");
	sleep_quiet_a: assert property (sleep_mode [*3] |-> !nmi)
		else $error("nmi in sleep");
	sel_move_a: assert property (
		!switch_enable_config_bit && !$past(rst) && !$past(rst, 2) && $changed(system_clock_sel)
		|-> $fell(switch_busy) || nmi || $past(nmi))
		else $error("source changed outside a switch");
endmodule
bind clock_switch_and_fail_monitor clksw_monitor mon_u (.mclk(mclk), .rst(rst), .rd_en(rd_en),
	.rd_data(rd_data), .sleep_mode(sleep_mode), .switch_enable_config_bit(switch_enable_config_bit),
	.switch_busy(switch_busy), .nmi(nmi), .system_clock_sel(system_clock_sel),
	.system_clock_run(system_clock_run));

// ---- dv/clock_switch_and_fail_monitor_tb.sv ----
// Self-checking bench for the clock switch controller
`timescale 1ns/10ps
module clock_switch_and_fail_monitor_tb
	import clksw_pkg::*;
;
	logic mclk = 0, rst = 1, wr_en = 0, rd_en = 0, cfg_off = 0, pll_lock = 0, sleep_mode = 0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wr_data = '0, rd_data, lfsr = 32'd26239;
	logic [2:0] init_src = SRC_FRC, sel;
	logic [OSC_N-1:0] tick_on = '1, osc_tick = '0, osc_enable, keep_osc = '0;
	logic [3:0] div_shift;
	logic busy, nmi, run, rd_p = 0;
	logic [63:0] exp_q[$];
	logic [63:0] e;
	int err_total = 0, cmp_count = 0, cyc = 0, nmi_cnt = 0, t;
	initial forever #2.5 mclk = ~mclk;
	clock_switch_and_fail_monitor #(.FAIL_CYCLES(16'd64)) dut_u (.mclk(mclk), .rst(rst),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.switch_enable_config_bit(cfg_off), .initial_source_config(init_src),
		.primary_submode_config(SUB_EC), .pll_from_primary(1'b0), .pll_lock(pll_lock),
		.sleep_mode(sleep_mode), .osc_tick(osc_tick), .periph_osc_request(keep_osc),
		.osc_enable(osc_enable), .system_clock_sel(sel), .system_clock_run(run),
		.fast_rc_div_shift(div_shift), .switch_busy(busy), .nmi(nmi));
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1;
		@(posedge mclk);
		wr_en <= 0;
	endtask
	// Notes the masked expectation; the watcher compares it
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] x);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1;
		exp_q.push_back({m, x});
		@(posedge mclk);
		rd_en <= 0;
	endtask
	task automatic unl;
		wr(OFS_SYS_KEY, KEY_FIRST);
		wr(OFS_SYS_KEY, KEY_SECOND);
	endtask
	// Clock-fail bit is written high so a real switch start must clear it
	task automatic req(input logic [2:0] s);
		unl();
		wr(OFS_OSC_CTRL, {21'h0, s, 8'h08});
		wr(OFS_OSC_SET, 32'h1);
		wr(OFS_SYS_KEY, 32'h0);
	endtask
	task automatic wt;
		t = 0;
		repeat (3) @(posedge mclk);
		while (busy !== 1'b0 && t < 3000)
		begin
			@(posedge mclk);
			t++;
		end
	endtask
	// Ticks pulse every other cycle on each source the block has enabled whose tick_on bit is set
	always @(posedge mclk)
	begin
		osc_tick <= rst ? '0 : (tick_on & osc_enable & ~osc_tick);
		rd_p <= rd_en;
		cyc <= cyc + 1;
		if (nmi === 1'b1)
			nmi_cnt++;
		if (rd_p && exp_q.size() > 0)
		begin
			e = exp_q.pop_front();
			chk("read data", rd_data & e[63:32], e[31:0]);
		end
		if (cyc == 20000)
		begin
			err_total++;
			results();
		end
	end
	initial
	begin
		repeat (20) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		rd(OFS_CLK_STAT, 32'hff, 32'h1);
		rd(OFS_SYS_KEY, '1, 32'h0);
		rd(12'h040, '1, 32'h0);
		wr(OFS_OSC_SET, 32'h401);
		repeat (4) @(posedge mclk);
		chk("busy locked", busy, 0);
		chk("run awake", run, 1);
		lfsr = nx(lfsr);
		wr(OFS_SYS_KEY, KEY_FIRST);
		wr(OFS_SYS_KEY, lfsr);
		wr(OFS_SYS_KEY, KEY_SECOND);
		wr(OFS_OSC_SET, 32'h401);
		repeat (4) @(posedge mclk);
		chk("busy bad key", busy, 0);
		req(SRC_FRC);
		wt();
		chk("redundant", 32'(t < 4), 1);
		tick_on[OSC_LOW_POWER_RC_OSC] <= 0;
		req(SRC_LOW_POWER_RC_OSC);
		repeat (40) @(posedge mclk);
		chk("busy no tick", busy, 1);
		tick_on[OSC_LOW_POWER_RC_OSC] <= 1;
		wt();
		chk("tick count", 32'(t >= 18 && t <= 20), 1);
		chk("sel low_power_rc_osc", sel, SRC_LOW_POWER_RC_OSC);
		chk("old osc off", osc_enable, 5'h08);
		req(SRC_PRI);
		wt();
		chk("no ost on ec", 32'(t < 30), 1);
		chk("sel pri", sel, SRC_PRI);
		chk("pri only", osc_enable, 5'h02);
		keep_osc[OSC_PRI] <= 1;
		req(SRC_SEC);
		wt();
		chk("startup", 32'(t > 2050 && t < 2090), 1);
		chk("sel sec", sel, SRC_SEC);
		chk("old osc kept", osc_enable, 5'h06);
		tick_on[OSC_SEC] <= 0;
		keep_osc <= '0;
		repeat (150) @(posedge mclk);
		chk("nmi count", nmi_cnt, 1);
		chk("sel fail", sel, SRC_FRC);
		rd(OFS_OSC_CTRL, 32'h8, 32'h8);
		tick_on <= '1;
		req(SRC_PLL);
		repeat (60) @(posedge mclk);
		chk("busy no lock", busy, 1);
		pll_lock <= 1;
		wt();
		chk("sel pll", sel, SRC_PLL);
		rd(OFS_OSC_CTRL, 32'h7009, 32'h1000);
		rd(OFS_CLK_STAT, 32'h80, 32'h80);
		wr(OFS_OSC_CTRL, {5'h0, 3'h7, 24'h100});
		repeat (2) @(posedge mclk);
		chk("relocked", div_shift, 0);
		unl();
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_OSC_CTRL, {5'h0, 3'(i), 13'h0, SRC_PLL, 8'h0});
			repeat (2) @(posedge mclk);
			chk("divider", div_shift, (i == 7) ? 8 : i);
		end
		tick_on <= '0;
		sleep_mode <= 1;
		repeat (100) @(posedge mclk);
		chk("run in sleep", run, 0);
		chk("nmi sleep", nmi_cnt, 1);
		$display("test 1 done");
		rst <= 1;
		sleep_mode <= 0;
		tick_on <= '1;
		cfg_off <= 1;
		init_src <= SRC_LOW_POWER_RC_OSC;
		repeat (20) @(posedge mclk);
		rst <= 0;
		repeat (3) @(posedge mclk);
		chk("sel cfg", sel, SRC_LOW_POWER_RC_OSC);
		req(SRC_SEC);
		repeat (4) @(posedge mclk);
		chk("busy off", busy, 0);
		rd(OFS_OSC_CTRL, 32'h7001, 32'h5000);
		tick_on <= '0;
		repeat (200) @(posedge mclk);
		chk("nmi off", nmi_cnt, 1);
		$display("test 2 done");
		results();
	end
endmodule
